// ---- flash_config_protect_cmds.sv ----
`timescale 1ns/1ps
module flash_config_protect_cmds (
   input wire logic clk,
   input wire logic sys_rst,
   input wire logic sck,
   input wire logic chipSelectN,
   input wire logic quadCommandMode,
   input wire logic [3:0] ioIn,
   output logic [3:0] ioOut,
   output logic [3:0] ioOe,
   output logic writeInProgress,
   output logic writeEnableLatch,
   output logic extendedAddressEnable,
   output logic [7:0] bankAddress,
   output logic [flash_cmd_pkg::BOOT_ADDR_W-1:0] bootStartAddress,
   output logic [flash_cmd_pkg::BOOT_DELAY_W-1:0] bootStartDelay,
   output logic bootEnable
);
   import flash_cmd_pkg::*;

   // ****************************************
   // state
   // ****************************************
   logic [31:0] bootConfig;
   logic [7:0] bankVol;
   logic [7:0] bankNv;
   logic write_enable_latch;
   logic write_in_progress;
   logic [15:0] busyCnt;
   logic clearWelAtEnd;
   logic [7:0] dynProt [SECTOR_COUNT];
   logic [7:0] persProt [SECTOR_COUNT];

   logic linkRst;
   logic fresh;
   logic [7:0] bitCnt;
   logic [7:0] opReg;
   logic [31:0] addrReg;
   logic [31:0] dataReg;
   logic [4:0] outCnt;
   logic [1:0] quadSync;
   logic [1:0] wipSync;
   logic [1:0] welSync;
   logic quadFrame;
   logic [2:0] step;
   logic [7:0] cnt;
   logic [7:0] hdr;
   logic [31:0] opNext;
   logic [3:0] linkSector;
   logic readOk;
   logic [7:0] readByte;
   logic [1:0] statusSnap;

   function automatic logic [31:0] shiftIn(input logic [31:0] v, input logic [3:0] pins,
                                           input logic quad);
      return quad ? {v[27:0], pins} : {v[30:0], pins[0]};
   endfunction

   // ****************************************
   // link side, clocked by the serial clock
   // ****************************************
   // chip select high parks the frame; the capture registers are not
   // cleared so the system side can still read the finished frame
   assign linkRst = sys_rst | chipSelectN;
   assign quadFrame = quadSync[1];
   assign step = quadFrame ? 3'h4 : 3'h1;
   assign cnt = fresh ? 8'h00 : bitCnt;
   assign hdr = headerBits(opReg, bankVol[EXT_ADDR_BIT]);
   assign opNext = shiftIn({24'h000000, opReg}, ioIn, quadFrame);
   assign linkSector = sectorOf(addrReg, hdr, bankVol);

   always_ff @(posedge sck or posedge sys_rst) begin
      if (sys_rst) begin
         quadSync <= 2'b00;
         wipSync <= 2'b00;
         welSync <= 2'b00;
      end else begin
         quadSync <= {quadSync[0], quadCommandMode};
         wipSync <= {wipSync[0], write_in_progress};
         welSync <= {welSync[0], write_enable_latch};
      end
   end

   always_ff @(posedge sck or posedge linkRst) begin
      if (linkRst) begin
         fresh <= 1'b1;
      end else begin
         fresh <= 1'b0;
      end
   end

   always_ff @(posedge sck or posedge sys_rst) begin
      if (sys_rst) begin
         bitCnt <= 8'h00;
         opReg <= 8'h00;
         addrReg <= 32'h0000_0000;
         dataReg <= 32'h0000_0000;
         outCnt <= 5'h00;
         statusSnap <= 2'b00;
      end else begin
         bitCnt <= (cnt > 8'hFB) ? 8'hFF : cnt + {5'h00, step};
         if (cnt < OPCODE_BITS) begin
            opReg <= opNext[7:0];
            outCnt <= 5'h00;
            // status is frozen at the opcode so a byte never mixes two states
            statusSnap <= {welSync[1], wipSync[1]};
         end else if (cnt < hdr) begin
            addrReg <= shiftIn(addrReg, ioIn, quadFrame);
         end else begin
            // four lines in quad mode, the input line otherwise
            dataReg <= shiftIn(dataReg, ioIn, quadFrame);
            outCnt <= outCnt + {2'b00, step};
         end
      end
   end

   // register values read here only change just after a frame ends,
   // while the serial clock is idle, so they are stable when shifted out
   always_comb begin
      readOk = 1'b1;
      readByte = 8'h00;
      case (opReg)
         OP_STATUS_READ: begin
            readByte = {6'h00, statusSnap};
         end
         OP_BOOT_CONFIG_READ: begin
            readByte = bootConfig[{outCnt[4:3], 3'b000} +: 8];
            readOk = !quadFrame;
         end
         OP_BANK_REG_READ, OP_BANK_REG_READ_ALT: begin
            readByte = bankVol;
         end
         OP_DYN_READ, OP_DYN_READ_WIDE: begin
            readByte = dynProt[linkSector];
         end
         OP_PERS_READ, OP_PERS_READ_WIDE: begin
            readByte = persProt[linkSector];
            readOk = !quadFrame;
         end
         default: begin
            readOk = 1'b0;
         end
      endcase
   end

   // data leaves on the falling edge; the address never advances, so a
   // long read simply repeats the same byte or word
   always_ff @(negedge sck or posedge linkRst) begin
      if (linkRst) begin
         ioOut <= 4'h0;
         ioOe <= 4'h0;
      end else if (!fresh && bitCnt >= OPCODE_BITS && bitCnt >= hdr && readOk) begin
         if (quadFrame) begin
            ioOut <= outCnt[2] ? readByte[3:0] : readByte[7:4];
            ioOe <= 4'hF;
         end else begin
            ioOut <= {2'b00, readByte[3'h7 - outCnt[2:0]], 1'b0};
            ioOe <= 4'h2;
         end
      end else begin
         ioOut <= 4'h0;
         ioOe <= 4'h0;
      end
   end

   // ****************************************
   // system side: frame end and decode
   // ****************************************
   logic [1:0] csSync;
   logic csPrev;
   logic frameEnd;
   logic [7:0] frameHdr;
   logic [3:0] frameSector;
   logic [31:0] bootWord;
   logic needWel;
   logic lenOk;
   logic known;
   logic accept;
   logic startsBusy;

   always_ff @(posedge clk or posedge sys_rst) begin
      if (sys_rst) begin
         csSync <= 2'b11;
         csPrev <= 1'b1;
      end else begin
         csSync <= {csSync[0], chipSelectN};
         csPrev <= csSync[1];
      end
   end

   // the capture registers are read only once chip select is seen high,
   // so the host must keep it high for three system clocks between frames
   assign frameEnd = csSync[1] & ~csPrev;
   assign frameHdr = headerBits(opReg, bankVol[EXT_ADDR_BIT]);
   assign frameSector = sectorOf(addrReg, frameHdr, bankVol);
   assign bootWord = {dataReg[7:0], dataReg[15:8], dataReg[23:16], dataReg[31:24]};

   always_comb begin
      needWel = 1'b1;
      lenOk = 1'b0;
      known = 1'b1;
      startsBusy = 1'b1;
      case (opReg)
         OP_WRITE_ENABLE: begin
            needWel = 1'b0;
            startsBusy = 1'b0;
            lenOk = bitCnt == OPCODE_BITS;
         end
         OP_BOOT_CONFIG_WRITE: begin
            lenOk = bitCnt == OPCODE_BITS + BOOT_WORD_BITS;
         end
         OP_BANK_REG_WRITE_NONVOLATILE, OP_BANK_REG_WRITE_VOLATILE_WE: begin
            lenOk = bitCnt == OPCODE_BITS + BYTE_BITS;
         end
         OP_BANK_REG_WRITE_VOLATILE: begin
            needWel = 1'b0;
            lenOk = bitCnt == OPCODE_BITS + BYTE_BITS;
         end
         OP_ENTER_FOUR_BYTE_MODE, OP_EXIT_FOUR_BYTE_MODE: begin
            needWel = 1'b0;
            startsBusy = 1'b0;
            lenOk = bitCnt == OPCODE_BITS;
         end
         OP_DYN_WRITE, OP_DYN_WRITE_WIDE: begin
            // only the two legal encodings are stored
            lenOk = bitCnt == frameHdr + BYTE_BITS &&
                    (dataReg[7:0] == PROTECT_OPEN ||
                     dataReg[7:0] == PROTECT_CLOSED);
         end
         OP_PERS_PROGRAM, OP_PERS_PROGRAM_WIDE: begin
            lenOk = bitCnt == frameHdr;
         end
         default: begin
            known = 1'b0;
            startsBusy = 1'b0;
         end
      endcase
   end

   // writes are refused while busy; a missing latch drops the command
   assign accept = frameEnd && known && lenOk && !write_in_progress && (write_enable_latch || !needWel);

   // ****************************************
   // latch and busy timer
   // ****************************************
   always_ff @(posedge clk or posedge sys_rst) begin
      if (sys_rst) begin
         write_enable_latch <= 1'b0;
      end else if (accept && opReg == OP_WRITE_ENABLE) begin
         write_enable_latch <= 1'b1;
      end else if (busyCnt == 16'h0001 && clearWelAtEnd) begin
         write_enable_latch <= 1'b0;
      end
   end

   always_ff @(posedge clk or posedge sys_rst) begin
      if (sys_rst) begin
         busyCnt <= 16'h0000;
         write_in_progress <= 1'b0;
         clearWelAtEnd <= 1'b0;
      end else if (accept && startsBusy) begin
         busyCnt <= WRITE_BUSY_CYCLES;
         write_in_progress <= 1'b1;
         clearWelAtEnd <= needWel;
      end else if (busyCnt != 16'h0000) begin
         busyCnt <= busyCnt - 16'h0001;
         write_in_progress <= busyCnt > 16'h0001;
      end
   end

   // ****************************************
   // configuration registers
   // ****************************************
   // values commit at frame end; the busy time only models the array
   always_ff @(posedge clk or posedge sys_rst) begin
      if (sys_rst) begin
         bootConfig <= BOOT_CONFIG_RESET;
      end else if (accept && opReg == OP_BOOT_CONFIG_WRITE) begin
         bootConfig <= bootWord;
      end
   end

   always_ff @(posedge clk or posedge sys_rst) begin
      if (sys_rst) begin
         bankVol <= BANK_RESET;
         bankNv <= BANK_RESET;
      end else if (accept) begin
         unique case (opReg)
            OP_BANK_REG_WRITE_NONVOLATILE: begin
               bankNv <= dataReg[7:0];
               bankVol <= dataReg[7:0];
            end
            OP_BANK_REG_WRITE_VOLATILE, OP_BANK_REG_WRITE_VOLATILE_WE: begin
               bankVol <= dataReg[7:0];
            end
            OP_ENTER_FOUR_BYTE_MODE: begin
               bankVol[EXT_ADDR_BIT] <= 1'b1;
            end
            OP_EXIT_FOUR_BYTE_MODE: begin
               bankVol[EXT_ADDR_BIT] <= 1'b0;
            end
            default: begin
            end
         endcase
      end
   end

   always_ff @(posedge clk or posedge sys_rst) begin
      if (sys_rst) begin
         for (int i = 0; i < SECTOR_COUNT; i++) begin
            dynProt[i] <= PROTECT_OPEN;
            persProt[i] <= PROTECT_OPEN;
         end
      end else if (accept) begin
         if (opReg == OP_DYN_WRITE || opReg == OP_DYN_WRITE_WIDE) begin
            dynProt[frameSector] <= dataReg[7:0];
         end
         if (opReg == OP_PERS_PROGRAM || opReg == OP_PERS_PROGRAM_WIDE) begin
            persProt[frameSector] <= PROTECT_CLOSED;
         end
      end
   end

   assign writeInProgress = write_in_progress;
   assign writeEnableLatch = write_enable_latch;
   assign extendedAddressEnable = bankVol[EXT_ADDR_BIT];
   assign bankAddress = bankVol;
   assign bootStartAddress = bootConfig[BOOT_ADDR_LSB +: BOOT_ADDR_W];
   assign bootStartDelay = bootConfig[BOOT_DELAY_LSB +: BOOT_DELAY_W];
   assign bootEnable = bootConfig[BOOT_ENABLE_BIT];

   // ****************************************
   // checks
   // ****************************************
   sequence busyStart;
      write_in_progress && busyCnt == WRITE_BUSY_CYCLES;
   endsequence

   a_boot_write: assert property (@(posedge clk) disable iff (sys_rst)
      accept && opReg == OP_BOOT_CONFIG_WRITE |=> bootConfig == $past(bootWord) ##0 busyStart)
      else $error("boot config write not applied");

   a_boot_discard: assert property (@(posedge clk) disable iff (sys_rst)
      frameEnd && opReg == OP_BOOT_CONFIG_WRITE && bitCnt != 8'h28 |=> $stable(bootConfig))
      else $error("short boot config write took effect");

   a_busy_length: assert property (@(posedge clk) disable iff (sys_rst)
      $rose(write_in_progress) |-> ##99 write_in_progress ##1 !write_in_progress)
      else $error("busy flag length wrong");

   a_busy_end: assert property (@(posedge clk) disable iff (sys_rst)
      write_in_progress && busyCnt == 16'h0001 && clearWelAtEnd |=> !write_in_progress && !write_enable_latch)
      else $error("latch or busy flag not cleared");

   a_missing_latch: assert property (@(posedge clk) disable iff (sys_rst)
      frameEnd && known && needWel && !write_enable_latch && !write_in_progress
      |=> !write_in_progress && $stable(bootConfig) && $stable(bankVol) && $stable(bankNv))
      else $error("command ran without latch");

   a_bank_both: assert property (@(posedge clk) disable iff (sys_rst)
      accept && opReg == OP_BANK_REG_WRITE_NONVOLATILE
      |=> bankNv == $past(dataReg[7:0]) && bankVol == bankNv)
      else $error("nonvolatile bank write wrong");

   a_volatile_open: assert property (@(posedge clk) disable iff (sys_rst)
      accept && opReg == OP_BANK_REG_WRITE_VOLATILE && !write_enable_latch |=> (!write_enable_latch && write_in_progress)[*3])
      else $error("volatile bank write touched latch");

   a_enter_four: assert property (@(posedge clk) disable iff (sys_rst)
      accept && opReg == OP_ENTER_FOUR_BYTE_MODE
      |=> extendedAddressEnable && $stable(bankNv) && !write_in_progress)
      else $error("enter four-byte mode failed");

   a_exit_four: assert property (@(posedge clk) disable iff (sys_rst)
      accept && opReg == OP_EXIT_FOUR_BYTE_MODE
      |=> !extendedAddressEnable && $stable(bankNv) && !write_in_progress)
      else $error("exit four-byte mode failed");

   a_pers_program: assert property (@(posedge clk) disable iff (sys_rst)
      accept && opReg == OP_PERS_PROGRAM_WIDE
      |=> persProt[$past(frameSector)] == PROTECT_CLOSED ##0 busyStart)
      else $error("persistent program failed");

   a_single_only: assert property (@(negedge sck) disable iff (linkRst)
      quadFrame && bitCnt >= OPCODE_BITS && (opReg == OP_BOOT_CONFIG_READ ||
      opReg == OP_PERS_READ || opReg == OP_PERS_READ_WIDE) |=> ioOe == 4'h0)
      else $error("single-line read answered in quad mode");
endmodule

// ---- flash_cmd_pkg.sv ----
package flash_cmd_pkg;
   localparam logic [7:0] OP_WRITE_ENABLE = 8'h06;
   localparam logic [7:0] OP_STATUS_READ = 8'h05;
   localparam logic [7:0] OP_BOOT_CONFIG_READ = 8'h14;
   localparam logic [7:0] OP_BOOT_CONFIG_WRITE = 8'h15;
   localparam logic [7:0] OP_BANK_REG_READ = 8'h16;
   localparam logic [7:0] OP_BANK_REG_READ_ALT = 8'hC8;
   localparam logic [7:0] OP_BANK_REG_WRITE_NONVOLATILE = 8'h18;
   localparam logic [7:0] OP_BANK_REG_WRITE_VOLATILE = 8'h17;
   localparam logic [7:0] OP_BANK_REG_WRITE_VOLATILE_WE = 8'hC5;
   localparam logic [7:0] OP_ENTER_FOUR_BYTE_MODE = 8'hB7;
   localparam logic [7:0] OP_EXIT_FOUR_BYTE_MODE = 8'h29;
   localparam logic [7:0] OP_DYN_READ = 8'hFA;
   localparam logic [7:0] OP_DYN_READ_WIDE = 8'hE0;
   localparam logic [7:0] OP_DYN_WRITE = 8'hFB;
   localparam logic [7:0] OP_DYN_WRITE_WIDE = 8'hE1;
   localparam logic [7:0] OP_PERS_READ = 8'hFC;
   localparam logic [7:0] OP_PERS_READ_WIDE = 8'hE2;
   localparam logic [7:0] OP_PERS_PROGRAM = 8'hFD;
   localparam logic [7:0] OP_PERS_PROGRAM_WIDE = 8'hE3;
   localparam logic [7:0] OPCODE_BITS = 8'h08;
   localparam logic [7:0] ADDR_SHORT_BITS = 8'h18;
   localparam logic [7:0] ADDR_WIDE_BITS = 8'h20;
   localparam logic [7:0] BYTE_BITS = 8'h08;
   localparam logic [7:0] BOOT_WORD_BITS = 8'h20;
   localparam int EXT_ADDR_BIT = 7;
   localparam int BANK_HIGH_BIT = 0;
   localparam int SECTOR_LSB = 21;
   localparam int SECTOR_COUNT = 16;
   localparam int BOOT_ENABLE_BIT = 0;
   localparam int BOOT_DELAY_LSB = 1;
   localparam int BOOT_DELAY_W = 4;
   localparam int BOOT_ADDR_LSB = 9;
   localparam int BOOT_ADDR_W = 23;
   localparam logic [31:0] BOOT_CONFIG_RESET = 32'h0000_0000;
   localparam logic [7:0] BANK_RESET = 8'h00;
   localparam logic [7:0] PROTECT_OPEN = 8'hFF;
   localparam logic [7:0] PROTECT_CLOSED = 8'h00;
   localparam int CLK_PERIOD_NS = 10;
   localparam int WRITE_BUSY_NS = 1000;
   localparam logic [15:0] WRITE_BUSY_CYCLES =
      16'((WRITE_BUSY_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);

   function automatic logic [7:0] headerBits(input logic [7:0] op, input logic ext);
      logic [7:0] bits;
      bits = OPCODE_BITS;
      if (op == OP_DYN_READ_WIDE || op == OP_DYN_WRITE_WIDE ||
          op == OP_PERS_READ_WIDE || op == OP_PERS_PROGRAM_WIDE) begin
         bits = OPCODE_BITS + ADDR_WIDE_BITS;
      end else if (op == OP_DYN_READ || op == OP_DYN_WRITE ||
                   op == OP_PERS_READ || op == OP_PERS_PROGRAM) begin
         bits = OPCODE_BITS + (ext ? ADDR_WIDE_BITS : ADDR_SHORT_BITS);
      end
      return bits;
   endfunction

   function automatic logic [3:0] sectorOf(input logic [31:0] addr, input logic [7:0] hdr,
                                           input logic [7:0] bank);
      logic [7:0] upper;
      upper = (hdr == OPCODE_BITS + ADDR_WIDE_BITS) ? addr[31:24] : bank;
      return {upper[BANK_HIGH_BIT], addr[SECTOR_LSB +: 3]};
   endfunction
endpackage

// ---- spi_host_model.sv ----
`timescale 1ns/1ps
module spi_host_model (
   output logic sck,
   output logic chipSelectN,
   output logic [3:0] ioIn,
   input wire logic quadCommandMode,
   input wire logic [3:0] ioOut,
   input wire logic [3:0] ioOe
);
   // ************************************
   // host frame driver, sck idles low
   // ************************************
   logic [3:0] oeSeen;

   initial begin
      sck = 1'b0;
      chipSelectN = 1'b1;
      ioIn = 4'h0;
      oeSeen = 4'h0;
   end

   // tx is right aligned and goes out msb first; chip select rises right after the last bit
   task automatic frame(input logic [71:0] tx, input int txBits, input int rxBits,
                        output logic [63:0] rx);
      int step;
      step = quadCommandMode ? 4 : 1;
      rx = '0;
      oeSeen = 4'h0;
      chipSelectN <= 1'b0;
      for (int i = txBits - step; i >= 0; i -= step) begin
         // each bit needs its own low phase, or only one rising edge is seen
         #40 sck <= 1'b0;
         ioIn <= (step == 4) ? tx[i +: 4] : {3'b000, tx[i]};
         #40 sck <= 1'b1;
      end
      for (int i = 0; i < rxBits; i += step) begin
         #40 sck <= 1'b0;
         ioIn <= ~ioIn;
         #40 rx = (step == 4) ? {rx[59:0], ioOut} : {rx[62:0], ioOut[1]};
         oeSeen = oeSeen | ioOe;
         sck <= 1'b1;
      end
      #40 sck <= 1'b0;
      ioIn <= ~ioIn;
      // exact count: the frame ends at the next low phase, no extra edge
      #40 chipSelectN <= 1'b1;
      #100;
   endtask
endmodule

// ---- tb.sv ----
`timescale 1ns/1ps
module tb;
   import flash_cmd_pkg::*;
   localparam logic [31:0] BOOT_WORD = 32'h1234_56A7;
   logic clk = 1'b0;
   logic sysRst = 1'b1;
   logic quadMode = 1'b0;
   logic sck, chipSelectN, writeInProgress, writeEnableLatch, extendedAddressEnable, bootEnable;
   logic [3:0] ioIn, ioOut, ioOe, bootStartDelay;
   logic [7:0] bankAddress;
   logic [BOOT_ADDR_W-1:0] bootStartAddress;
   logic [63:0] rx;
   int nErrors = 0;
   int checksDone = 0;

   always #5 clk = ~clk;

   flash_config_protect_cmds i_flash_config_protect_cmds (.clk(clk), .sys_rst(sysRst),
      .sck(sck), .chipSelectN(chipSelectN), .quadCommandMode(quadMode), .ioIn(ioIn),
      .ioOut(ioOut), .ioOe(ioOe), .writeInProgress(writeInProgress),
      .writeEnableLatch(writeEnableLatch), .extendedAddressEnable(extendedAddressEnable),
      .bankAddress(bankAddress), .bootStartAddress(bootStartAddress),
      .bootStartDelay(bootStartDelay), .bootEnable(bootEnable));

   spi_host_model i_spi_host_model (.sck(sck), .chipSelectN(chipSelectN), .ioIn(ioIn),
      .quadCommandMode(quadMode), .ioOut(ioOut), .ioOe(ioOe));

   // ************************************
   // tasks
   // ************************************
   task automatic conclude();
      if (nErrors == 0 && checksDone > 0) begin
         $display("Test passed");
      end else begin
         $display("Test failed");
      end
      $finish;
   endtask

   task automatic checkVal(input string what, input logic [63:0] exp, input logic [63:0] got);
      checksDone++;
      if (got !== exp) begin
         nErrors++;
         $display("wrong value %s expected %h seen %h", what, exp, got);
      end
   endtask

   task automatic cmd(input logic [71:0] tx, input int txBits, input int rxBits);
      i_spi_host_model.frame(tx, txBits, rxBits, rx);
   endtask

   task automatic wen();
      cmd(72'(OP_WRITE_ENABLE), 8, 0);
   endtask

   task automatic waitIdle();
      int n;
      n = 0;
      while (writeInProgress !== 1'b0 && n < 300) begin
         @(posedge clk);
         n++;
      end
      if (n >= 300) begin
         nErrors++;
         conclude();
      end
   endtask

   initial begin
      #900000;
      nErrors++;
      conclude();
   end

   // ************************************
   // scenarios
   // ************************************
   initial begin
      repeat (8) @(posedge clk);
      sysRst <= 1'b0;
      repeat (4) @(posedge clk);
      checkVal("reset", {BANK_RESET, 3'b000}, {bankAddress, writeInProgress, writeEnableLatch, bootEnable});
      // reserved bank bits are always sent as zero
      cmd({OP_BANK_REG_WRITE_VOLATILE, 8'h01}, 16, 0);
      checkVal("busy", 1'b1, writeInProgress);
      waitIdle();
      checkVal("bank", 9'h002, {bankAddress, writeEnableLatch});
      cmd({OP_BANK_REG_WRITE_VOLATILE_WE, 8'h00}, 16, 0);
      checkVal("bank", 9'h002, {bankAddress, writeInProgress});
      cmd(72'(OP_BANK_REG_READ), 8, 16);
      checkVal("bank read", 16'h0101, rx);
      checkVal("read enable", 4'h2, i_spi_host_model.oeSeen);
      wen();
      cmd({OP_BOOT_CONFIG_WRITE, 8'hA7, 8'h56, 8'h34, 8'h12}, 40, 0);
      cmd(72'(OP_STATUS_READ), 8, 8);
      checkVal("status", 8'h03, rx);
      waitIdle();
      checkVal("latch", 1'b0, writeEnableLatch);
      checkVal("boot", {BOOT_WORD[31:9], BOOT_WORD[4:0]},
               {bootStartAddress, bootStartDelay, bootEnable});
      cmd(72'(OP_BOOT_CONFIG_READ), 8, 64);
      checkVal("boot read", 64'hA756_3412_A756_3412, rx);
      wen();
      cmd({OP_BOOT_CONFIG_WRITE, 31'h0}, 39, 0);
      checkVal("short boot", {BOOT_WORD[0], 1'b0}, {bootEnable, writeInProgress});
      cmd({OP_BANK_REG_WRITE_VOLATILE_WE, 8'h00}, 16, 0);
      waitIdle();
      checkVal("bank", 9'h000, {bankAddress, writeEnableLatch});
      wen();
      cmd({OP_BANK_REG_WRITE_NONVOLATILE, 8'h01}, 16, 0);
      waitIdle();
      checkVal("bank", 9'h002, {bankAddress, writeEnableLatch});
      // a short frame lets the mode synchroniser settle before real traffic
      quadMode <= 1'b1;
      cmd(72'h0, 8, 0);
      cmd(72'(OP_BANK_REG_READ_ALT), 8, 16);
      checkVal("quad bank", 16'h0101, rx);
      cmd(72'(OP_BOOT_CONFIG_READ), 8, 32);
      checkVal("quad boot", 4'h0, i_spi_host_model.oeSeen);
      cmd({OP_PERS_READ_WIDE, 32'h0}, 40, 8);
      checkVal("quad pers", 4'h0, i_spi_host_model.oeSeen);
      quadMode <= 1'b0;
      cmd(72'h0, 8, 0);
      wen();
      cmd({OP_DYN_WRITE, 24'h20_0000, PROTECT_CLOSED}, 40, 0);
      waitIdle();
      cmd({OP_DYN_READ_WIDE, 32'h0120_0000}, 40, 16);
      checkVal("dyn 9", 16'h0000, rx);
      cmd({OP_DYN_READ_WIDE, 32'h0020_0000}, 40, 8);
      checkVal("dyn 1", 8'hFF, rx);
      wen();
      cmd({OP_DYN_WRITE_WIDE, 32'h0040_0000, 8'h5A}, 48, 0);
      waitIdle();
      cmd({OP_DYN_READ, 24'h40_0000}, 32, 8);
      checkVal("dyn 10", 8'hFF, rx);
      wen();
      cmd({OP_PERS_PROGRAM_WIDE, 32'h0140_0000}, 40, 0);
      checkVal("pers busy", 1'b1, writeInProgress);
      waitIdle();
      checkVal("latch", 1'b0, writeEnableLatch);
      cmd({OP_PERS_PROGRAM_WIDE, 32'h0160_0000}, 40, 0);
      checkVal("no latch", 1'b0, writeInProgress);
      cmd(72'(OP_ENTER_FOUR_BYTE_MODE), 8, 0);
      checkVal("enter", 10'h302, {extendedAddressEnable, bankAddress, writeEnableLatch});
      cmd({OP_PERS_READ, 32'h0140_0000}, 40, 16);
      checkVal("pers 10", 16'h0000, rx);
      cmd({OP_PERS_READ_WIDE, 32'h0160_0000}, 40, 8);
      checkVal("pers 11", 8'hFF, rx);
      cmd({OP_DYN_READ, 32'h0120_0000}, 40, 8);
      checkVal("dyn wide", 8'h00, rx);
      cmd(72'(OP_EXIT_FOUR_BYTE_MODE), 8, 0);
      checkVal("exit", 9'h001, {extendedAddressEnable, bankAddress});
      conclude();
   end
endmodule
